// ---- hw/tlas_pkg.sv ----
/*
  Package for the talker/listener address status block: register offset,
  bit positions, address modes and the decoded bus-event carrier.
  Assumes the surrounding chip decodes bus commands into one-cycle events.
*/
package tlas_pkg;

  localparam logic [3:0] TLAS_STATUS_OFFSET = 4'h9;

  localparam int TLAS_BIT_MINOR    = 0;
  localparam int TLAS_BIT_TALK     = 1;
  localparam int TLAS_BIT_LISTEN   = 2;
  localparam int TLAS_BIT_TPS      = 3;

  localparam logic [7:0] TLAS_STATUS_RESET = 8'h00;

  // address mode field encodings
  localparam logic [1:0] TLAS_MODE_NONE   = 2'h0;
  localparam logic [1:0] TLAS_MODE_DUAL   = 2'h1;
  localparam logic [1:0] TLAS_MODE_EXT    = 2'h2;
  localparam logic [1:0] TLAS_MODE_EXTDUAL = 2'h3;

  typedef struct packed {
    logic my_talk_major;
    logic my_talk_minor;
    logic my_listen_major;
    logic my_listen_minor;
    logic my_secondary;
    logic other_command;
    logic other_talk;
    logic unlisten;
    logic untalk;
    logic serial_poll;
  } tlas_event_type;

  typedef struct packed {
    logic [1:0] addr_mode;
    logic       listen_only;
    logic       talk_only;
  } tlas_mode_type;

endpackage

// ---- hw/tlas_address_status.sv ----
/*
  Address status register of the talker/listener: tracks talker and
  listener addressing, primary-address reception and major/minor identity.
  Assumes bus events are already decoded, one-cycle and synchronous; the
  register is read at offset 9 through a simple read-only port.
*/
`timescale 1ns/10ps

module tlas_address_status (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    chip_reset,
  input  wire tlas_pkg::tlas_event_type bus_event,
  input  wire tlas_pkg::tlas_mode_type  mode,
  input  wire logic                    reg_read,
  input  wire logic [3:0]              reg_addr,
  output logic [7:0]                   reg_rdata,
  output logic                         reg_rvalid,
  output logic                         talker_state,
  output logic                         listener_state
);

  ////////////////////////////////////////////////////////////////////////
  logic talk_q, talk_d;
  logic listen_q, listen_d;
  logic tps_q, tps_d;
  logic minor_q, minor_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic ext_mode;
  logic dual_mode;
  logic talk_hit;
  logic listen_hit;

  assign ext_mode  = (mode.addr_mode == tlas_pkg::TLAS_MODE_EXT) ||
                     (mode.addr_mode == tlas_pkg::TLAS_MODE_EXTDUAL);
  assign dual_mode = (mode.addr_mode == tlas_pkg::TLAS_MODE_DUAL) ||
                     (mode.addr_mode == tlas_pkg::TLAS_MODE_EXTDUAL);

  always_comb begin
    talk_hit   = 1'b0;
    listen_hit = 1'b0;
    if (ext_mode) begin
      talk_hit = tps_q && bus_event.my_secondary;
      listen_hit = bus_event.my_listen_major || bus_event.my_listen_minor;
    end else begin
      talk_hit   = bus_event.my_talk_major || bus_event.my_talk_minor;
      listen_hit = bus_event.my_listen_major || bus_event.my_listen_minor;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    talk_d   = talk_q;
    listen_d = listen_q;
    tps_d    = tps_q;
    minor_d  = minor_q;
    if (ext_mode && (bus_event.my_talk_major || bus_event.my_talk_minor)) begin
      tps_d = 1'b1;
    end else if (bus_event.other_command || bus_event.my_secondary) begin
      tps_d = 1'b0;
    end
    if (bus_event.other_talk || bus_event.untalk) begin
      talk_d = 1'b0;
    end
    if (bus_event.unlisten) begin
      listen_d = 1'b0;
    end
    if (talk_hit || mode.talk_only) begin
      talk_d = 1'b1;
      listen_d = 1'b0;
    end
    if (bus_event.serial_poll && talk_q) begin
      talk_d = 1'b1;
    end
    // listen addressed sources, applied after the talk sources so listen wins
    if (listen_hit || mode.listen_only) begin
      listen_d = 1'b1;
      talk_d = 1'b0;
    end
    if (bus_event.my_talk_minor || bus_event.my_listen_minor) begin
      minor_d = 1'b1;
    end else if (bus_event.my_talk_major || bus_event.my_listen_major) begin
      minor_d = 1'b0;
    end
    if (!dual_mode) begin
      minor_d = 1'b0;
    end
    if (chip_reset) begin
      talk_d   = 1'b0;
      listen_d = 1'b0;
      tps_d    = 1'b0;
      minor_d  = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      talk_q   <= 1'b0;
      listen_q <= 1'b0;
      tps_q    <= 1'b0;
      minor_q  <= 1'b0;
    end else begin
      talk_q   <= talk_d;
      listen_q <= listen_d;
      tps_q    <= tps_d;
      minor_q  <= minor_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata_d  = tlas_pkg::TLAS_STATUS_RESET;
    rvalid_d = 1'b0;
    if (reg_read && (reg_addr == tlas_pkg::TLAS_STATUS_OFFSET)) begin
      rvalid_d = 1'b1;
      rdata_d[tlas_pkg::TLAS_BIT_LISTEN] = listen_q;
      rdata_d[tlas_pkg::TLAS_BIT_TALK]   = talk_q;
      rdata_d[tlas_pkg::TLAS_BIT_TPS]    = tps_q;
      // masked at once when a single-primary mode is chosen
      rdata_d[tlas_pkg::TLAS_BIT_MINOR]  = minor_q && dual_mode;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q  <= tlas_pkg::TLAS_STATUS_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata      = rdata_q;
  assign reg_rvalid     = rvalid_q;
  assign talker_state   = talk_q;
  assign listener_state = listen_q;

endmodule

// ---- verification/tlas_chk.sv ----
/* assertions on the status block ports; bound from the bench top file */
`timescale 1ns/10ps
module tlas_chk (
  input logic clock, rst, chip_reset, reg_read, reg_rvalid, talker_state, listener_state,
  input tlas_pkg::tlas_event_type bus_event,
  input tlas_pkg::tlas_mode_type  mode,
  input logic [3:0]               reg_addr,
  input logic [7:0]               reg_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // quiet status read: no event, no reset, no forced mode
  sequence s_rd;
    reg_read && reg_addr == 4'h9 && bus_event == '0 && !chip_reset && mode == '0;
  endsequence
  a_listen_set:
    assert property (bus_event.my_listen_major && !chip_reset |=> listener_state && !talker_state)
    else $error("listen");
  a_talk_set:
    assert property (bus_event == 10'h200 && mode == '0 && !chip_reset |=>
      talker_state && !listener_state) else $error("talk");
  a_chip_clear:
    assert property (chip_reset && mode[1:0] == 2'h0 |=> !talker_state && !listener_state)
    else $error("clear");
  a_never_both:
    assert property (!(talker_state && listener_state)) else $error("both");
  a_read_data:
    assert property (s_rd |=> reg_rvalid && reg_rdata[2:1] == {listener_state, talker_state})
    else $error("read");
  a_read_refuse:
    assert property (reg_read && reg_addr != 4'h9 |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("refuse");
  a_read_quiet:
    assert property (s_rd |=> $stable(talker_state) && $stable(listener_state)) else $error("quiet");
  a_minor_zero:
    assert property (reg_rvalid && !$past(mode.addr_mode[0]) |-> !reg_rdata[0]) else $error("minor");
endmodule

// ---- verification/tlas_ctl_model.sv ----
/* bus-side model: replays a command as a one-cycle event; free-running clock */
`timescale 1ns/10ps
module tlas_ctl_model (
  input  logic                     clock, go,
  input  tlas_pkg::tlas_event_type cmd,
  output tlas_pkg::tlas_event_type bus_event
);
  always_ff @(posedge clock) bus_event <= go ? cmd : '0;
endmodule

// ---- verification/tlas_address_status_tb.sv ----
/* bench for the status block; bus model feeds events, reads via offset port */
`timescale 1ns/10ps
module tlas_address_status_tb;
  typedef struct packed {logic [3:0] m; logic [9:0] a, b; logic [7:0] r;} tlas_row_type;
  logic clock = 0, rst = 1, chip_reset = 0, go = 0, reg_read = 0;
  logic reg_rvalid, talker_state, listener_state;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_rdata;
  tlas_pkg::tlas_event_type cmd = '0, bus_event;
  tlas_pkg::tlas_mode_type mode = '0;
  int failures = 0, cmp_count = 0;
  tlas_row_type rows [11] = '{
    {4'h0, 10'h080, 10'h000, 8'h04}, {4'h0, 10'h200, 10'h000, 8'h02},
    {4'h2, 10'h000, 10'h000, 8'h04}, {4'h1, 10'h000, 10'h000, 8'h02},
    {4'h0, 10'h080, 10'h200, 8'h02}, {4'h0, 10'h200, 10'h080, 8'h04},
    {4'h4, 10'h040, 10'h000, 8'h05}, {4'h4, 10'h100, 10'h080, 8'h04},
    {4'h8, 10'h200, 10'h000, 8'h08}, {4'hC, 10'h200, 10'h020, 8'h02},
    {4'h0, 10'h200, 10'h009, 8'h02}};
  tlas_ctl_model u_tlas_ctl_model (.clock(clock), .go(go), .cmd(cmd), .bus_event(bus_event));
  tlas_address_status u_tlas_address_status (
    .clock(clock), .rst(rst), .chip_reset(chip_reset), .bus_event(bus_event), .mode(mode),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .talker_state(talker_state), .listener_state(listener_state));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ev(logic [9:0] e);
    @(posedge clock) go <= 1;
    cmd <= e;
    @(posedge clock) go <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [8:0] x);
    @(posedge clock) reg_read <= 1;
    reg_addr <= a;
    @(posedge clock) reg_read <= 0;
    @(negedge clock);
    chk("rvalid", {7'h0, x[8]}, {7'h0, reg_rvalid});
    chk("rdata", x[7:0], reg_rdata);
  endtask
  task automatic final_report;
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #5 clock = ~clock;
  initial begin
    repeat (6) @(negedge clock);
    chk("rdata", 8'h00, reg_rdata);
    @(posedge clock) rst <= 0;
    foreach (rows[i]) begin
      @(posedge clock) mode <= rows[i].m;
      chip_reset <= 1;
      @(posedge clock) chip_reset <= 0;
      ev(rows[i].a);
      ev(rows[i].b);
      rd(4'h9, {1'b1, rows[i].r});
    end
    rd(4'h8, 9'h000);
    @(posedge clock) chip_reset <= 1;
    @(posedge clock) chip_reset <= 0;
    rd(4'h9, 9'h100);
    ev(10'h080);
    @(posedge clock);
    @(negedge clock);
    chk("listener", 8'h01, {7'h0, listener_state});
    @(posedge clock) rst <= 1;
    @(posedge clock) rst <= 0;
    @(negedge clock);
    chk("listener", 8'h00, {7'h0, listener_state});
    final_report;
  end
endmodule
bind tlas_address_status tlas_chk u_tlas_chk (
  .clock(clock), .rst(rst), .chip_reset(chip_reset), .reg_read(reg_read),
  .reg_rvalid(reg_rvalid), .talker_state(talker_state), .listener_state(listener_state),
  .bus_event(bus_event), .mode(mode), .reg_addr(reg_addr), .reg_rdata(reg_rdata));
